// *** verilog/dlr_pkg.sv ***
// constants, encodings and reset values of the display list renderer
//Contract
//- writing 0x02 to list swap control activates the new list at next frame
//- every line's list fetch starts at display list memory base
//- one 32-bit command per word; fetch byte address steps by four
//- list ends with display command; fetching stops there
//- screens up to 2048 by 2048 pixels; fixed-point vertices reach that only at vertex formats 0-3
//- integer vertex is unsigned; fixed-point vertex is signed
//- orientation select write takes effect at once, no swap needed
//- drawing coordinates follow the selected rotation or mirroring
//- orientation select write leaves touch transform coefficients untouched
//- orientation codes 0-3 landscape, inv landscape, portrait, inv portrait; 4-7 mirrored
//- begin sets primitive, vertices place instances, end closes it
//- line width is half the full line thickness
//- rectangles grow by width both ways, width is corner radius
//- sampling x'=Ax+By+C, y'=Dx+Ey+F, identity by default
//- draw colour modulates bitmaps, white when not set
//- draw alpha 0 transparent, 255 opaque, between blends
//- each line is composited from the list during scan-out
//- line time follows divider and line period, never below 2048 cycles
//- one command fetched per clock; lists below 2048 commands
//- nearest filter draws 16 pixels per clock, 8 for text/indexed
//- bilinear filter draws a quarter: 4, or 2 for text/indexed
package dlr_pkg;
   // register offsets on the plain port
   localparam logic [13:0] OFS_SWAP    = 14'h0000;
   localparam logic [13:0] OFS_ROTATE  = 14'h0004;
   localparam logic [13:0] OFS_PCLK    = 14'h0008;
   localparam logic [13:0] OFS_HCYCLE  = 14'h000c;
   localparam logic [13:0] OFS_STATUS  = 14'h0010;
   localparam int          LIST_SEL_BIT = 13;
   // status field positions
   localparam int ST_BANK_BIT = 0;
   localparam int ST_OVR_BIT  = 1;
   localparam int ST_PEND_BIT = 2;
   localparam int ST_OK_BIT   = 3;
   localparam int ST_BUSY_BIT = 4;
   localparam int ST_ROW_LSB  = 16;
   // swap and fetch figures
   localparam logic [7:0]  SWAP_FRAME   = 8'h02;
   localparam logic [13:0] CMD_BYTES    = 14'h0004;
   localparam logic [13:0] LIST_BYTES   = 14'h2000;
   localparam logic [19:0] MIN_LINE_CYC = 20'h00800;
   // reset values
   localparam logic [2:0]  ROT_RST   = 3'h0;
   localparam logic [7:0]  PCLK_RST  = 8'h00;
   localparam logic [11:0] HCYC_RST  = 12'h000;
   localparam logic [23:0] RGB_WHITE = 24'hffffff;
   localparam logic [7:0]  ALPHA_MAX = 8'hff;
   localparam logic [11:0] LW_RST    = 12'h010;
   localparam logic [2:0]  VFMT_RST  = 3'h4;
   localparam logic [15:0] COEF_ONE  = 16'h0100;
   localparam logic [15:0] COEF_ZERO = 16'h0000;
   // command fields
   localparam logic [1:0] TAG_VINT = 2'h2;
   localparam logic [1:0] TAG_VFIX = 2'h1;
   localparam logic [7:0] OP_DISPLAY = 8'h00;
   localparam logic [7:0] OP_BEGIN   = 8'h01;
   localparam logic [7:0] OP_END     = 8'h02;
   localparam logic [7:0] OP_RGB     = 8'h03;
   localparam logic [7:0] OP_ALPHA   = 8'h04;
   localparam logic [7:0] OP_LWIDTH  = 8'h05;
   localparam logic [7:0] OP_VFMT    = 8'h06;
   localparam logic [7:0] OP_BMODE   = 8'h07;
   localparam logic [7:0] OP_XF_A    = 8'h08;
   localparam logic [7:0] OP_XF_F    = 8'h0d;
   // primitive kinds
   localparam logic [3:0] PK_NONE   = 4'h0;
   localparam logic [3:0] PK_POINTS = 4'h1;
   localparam logic [3:0] PK_BITMAP = 4'h2;
   localparam logic [3:0] PK_LINES  = 4'h3;
   localparam logic [3:0] PK_STRIP  = 4'h4;
   localparam logic [3:0] PK_RECTANGLE_PRIMITIVE  = 4'h5;
   localparam logic [3:0] PK_EDGE_A = 4'h6;
   localparam logic [3:0] PK_EDGE_L = 4'h9;
   // pixel rates per clock
   localparam logic [4:0] RATE_NEAR      = 5'h10;
   localparam logic [4:0] RATE_NEAR_TXT  = 5'h08;
   localparam logic [4:0] RATE_BILIN     = 5'h04;
   localparam logic [4:0] RATE_BILIN_TXT = 5'h02;
   // fetch states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FETCH = 3'b010,
      ST_DONE  = 3'b100
   } dlr_state_t;
endpackage

// *** verilog/dlr_list_mem.sv ***
// two-bank display list memory with registered read data
`timescale 1ns/1ps
module dlr_list_mem #(
   parameter int AW = 12,
   parameter int DW = 32
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          sys_rst,
   // write side
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // read side
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);
   logic [DW-1:0] mem [2**AW];

   // storage write
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // read data one cycle after the address
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// *** verilog/dlr_top.sv ***
// display list renderer: register port, list fetch, primitive assembly
`timescale 1ns/1ps
module dlr_top #(
   parameter int SCR_W       = 480,
   parameter int SCR_H       = 272,
   parameter int FRAME_LINES = 272
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // register port
   input  wire logic [13:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // scan-out timing
   output logic             frame_pulse,
   output logic             line_pulse,
   output logic      [2:0]  orientation,
   output logic             overrun,
   // primitive instances
   output logic             prim_valid,
   output logic      [3:0]  prim_kind,
   output logic      [11:0] prim_x0,
   output logic      [11:0] prim_y0,
   output logic      [11:0] prim_x1,
   output logic      [11:0] prim_y1,
   output logic      [7:0]  prim_radius,
   output logic      [23:0] prim_rgb,
   output logic      [7:0]  prim_alpha,
   output logic      [15:0] prim_u,
   output logic      [15:0] prim_v,
   output logic      [4:0]  prim_rate
);
   localparam logic signed [11:0] XMAX = 12'(SCR_W - 1);
   localparam logic signed [11:0] YMAX = 12'(SCR_H - 1);
   localparam logic [11:0]        ROWS = 12'(FRAME_LINES - 1);

   dlr_pkg::dlr_state_t st_q, st_d;
   logic [2:0]  orient_q;
   logic [7:0]  pclk_q;
   logic [11:0] hcyc_q;
   logic        bank_q, pend_q, ok_q, ovr_q;
   logic [13:0] fetch_addr_q;
   logic        rd_vld_q;
   logic [19:0] line_cnt_q;
   logic [11:0] row_q;
   logic [3:0]  kind_q;
   logic        have_q;
   logic signed [11:0] px_q, py_q;
   logic [23:0] rgb_q;
   logic [7:0]  alpha_q;
   logic [11:0] lw_q;
   logic [2:0]  vfmt_q;
   logic        filt_q, fmtc_q;
   logic signed [15:0] coef_q [6];
   logic [31:0] rdata_q;
   logic        fpul_q, lpul_q, pv_q;
   logic [3:0]  pk_q;
   logic [11:0] px0_q, py0_q, px1_q, py1_q;
   logic [7:0]  prad_q, palpha_q;
   logic [23:0] prgb_q;
   logic [15:0] pu_q, pv16_q;
   logic [4:0]  prate_q;
   logic [31:0] cmd;

   // rotate or mirror a logical point into screen space
   function automatic logic [23:0] dlr_rot(input logic [2:0] o,
                                           input logic signed [11:0] x,
                                           input logic signed [11:0] y);
      logic signed [11:0] a;
      logic signed [11:0] b;
      a = x;
      b = y;
      unique case (o[1:0])
         2'h0: begin a = x;        b = y;        end
         2'h1: begin a = XMAX - x; b = YMAX - y; end
         2'h2: begin a = XMAX - y; b = x;        end
         2'h3: begin a = y;        b = YMAX - x; end
      endcase
      if (o[2]) begin
         a = XMAX - a;                           // mirrored forms
      end
      return {a, b};
   endfunction

   // register port decode
   wire        sel_list  = reg_addr[dlr_pkg::LIST_SEL_BIT];
   wire        wr_swap   = reg_wr && reg_addr == dlr_pkg::OFS_SWAP;
   wire        wr_rot    = reg_wr && reg_addr == dlr_pkg::OFS_ROTATE;
   wire        wr_pclk   = reg_wr && reg_addr == dlr_pkg::OFS_PCLK;
   wire        wr_hcyc   = reg_wr && reg_addr == dlr_pkg::OFS_HCYCLE;
   wire        wr_stat   = reg_wr && reg_addr == dlr_pkg::OFS_STATUS;
   wire        swap_req  = wr_swap && reg_wdata[7:0] == dlr_pkg::SWAP_FRAME;
   wire        list_wr   = reg_wr && sel_list;
   wire [11:0] list_wa   = {~bank_q, reg_addr[12:2]};
   wire        ovr_clr   = wr_stat && reg_wdata[dlr_pkg::ST_OVR_BIT];
   wire [31:0] status    = {4'h0, row_q, 11'h000, st_q == dlr_pkg::ST_FETCH,
                            ok_q, pend_q, ovr_q, bank_q};
   wire [31:0] rd_mux    =
      sel_list                        ? 32'h0000_0000 :
      reg_addr == dlr_pkg::OFS_SWAP   ? {24'h000000, pend_q ? dlr_pkg::SWAP_FRAME : 8'h00} :
      reg_addr == dlr_pkg::OFS_ROTATE ? {29'h0, orient_q} :
      reg_addr == dlr_pkg::OFS_PCLK   ? {24'h0, pclk_q} :
      reg_addr == dlr_pkg::OFS_HCYCLE ? {20'h0, hcyc_q} :
      reg_addr == dlr_pkg::OFS_STATUS ? status : 32'h0000_0000;

   // line and frame timing, never shorter than the minimum line
   wire [19:0] period    = 20'(pclk_q) * 20'(hcyc_q);
   wire [19:0] line_len  = (period < dlr_pkg::MIN_LINE_CYC) ? dlr_pkg::MIN_LINE_CYC : period;
   wire        run       = pclk_q != 8'h00;
   wire        line_go   = run && line_cnt_q == line_len - 20'h1;
   wire        frame_go  = line_go && row_q == ROWS;
   wire        take_swap = frame_go && pend_q;

   // command decode
   wire        cmd_vld   = rd_vld_q && st_q == dlr_pkg::ST_FETCH;
   wire [7:0]  op        = cmd[31:24];
   wire        is_vint   = cmd[31:30] == dlr_pkg::TAG_VINT;
   wire        is_vfix   = cmd[31:30] == dlr_pkg::TAG_VFIX;
   wire        is_op     = cmd[31:30] == 2'h0;
   wire        dl_stop   = cmd_vld && is_op && op == dlr_pkg::OP_DISPLAY;
   wire        fetch_full = fetch_addr_q == dlr_pkg::LIST_BYTES;
   wire        fetch_adv = st_q == dlr_pkg::ST_FETCH && !dl_stop && !line_go && !fetch_full;
   wire        op_xf     = is_op && op >= dlr_pkg::OP_XF_A && op <= dlr_pkg::OP_XF_F;

   // vertex decode: integer form unsigned, fixed form signed and scaled
   wire signed [14:0] fx15 = $signed(cmd[29:15]) >>> vfmt_q;
   wire signed [14:0] fy15 = $signed(cmd[14:0]) >>> vfmt_q;
   wire signed [11:0] vx = is_vint ? {1'b0, cmd[21:11]} : fx15[11:0];
   wire signed [11:0] vy = is_vint ? {1'b0, cmd[10:0]}  : fy15[11:0];
   wire [23:0]  rot_xy  = dlr_rot(orient_q, vx, vy);
   wire signed [11:0] rx = rot_xy[23:12];
   wire signed [11:0] ry = rot_xy[11:0];
   wire         vtx_cmd = cmd_vld && (is_vint || is_vfix);

   // primitive assembly
   wire signed [11:0] w = {4'h0, lw_q[11:4]};
   wire single   = kind_q == dlr_pkg::PK_POINTS || kind_q == dlr_pkg::PK_BITMAP;
   wire paired   = kind_q == dlr_pkg::PK_LINES || kind_q == dlr_pkg::PK_RECTANGLE_PRIMITIVE;
   wire is_rect  = kind_q == dlr_pkg::PK_RECTANGLE_PRIMITIVE;
   wire emit     = vtx_cmd && kind_q != dlr_pkg::PK_NONE && (single || have_q);
   wire signed [11:0] e_x0 = single ? rx : (is_rect ? px_q - w : px_q);
   wire signed [11:0] e_y0 = single ? ry : (is_rect ? py_q - w : py_q);
   wire signed [11:0] e_x1 = is_rect ? rx + w : rx;
   wire signed [11:0] e_y1 = is_rect ? ry + w : ry;
   wire [7:0]  e_rad  = single ? 8'h00 : lw_q[11:4];
   wire        have_d = vtx_cmd ? ((single || (paired && have_q)) ? 1'b0 : 1'b1) : have_q;

   // affine sampling of the vertex, A, B, D, E in 8.8 form, C and F in whole pixels
   wire signed [29:0] u_sum = 30'(coef_q[0]) * 30'(vx) + 30'(coef_q[1]) * 30'(vy)
                              + {{6{coef_q[2][15]}}, coef_q[2], 8'h00};
   wire signed [29:0] v_sum = 30'(coef_q[3]) * 30'(vx) + 30'(coef_q[4]) * 30'(vy)
                              + {{6{coef_q[5][15]}}, coef_q[5], 8'h00};
   wire [4:0] rate = filt_q ? (fmtc_q ? dlr_pkg::RATE_BILIN_TXT : dlr_pkg::RATE_BILIN)
                            : (fmtc_q ? dlr_pkg::RATE_NEAR_TXT  : dlr_pkg::RATE_NEAR);

   // list memory: host fills the idle bank, renderer reads the active one
   dlr_list_mem #(
      .AW (12),
      .DW (32)
   ) u_mem (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (list_wr),
      .wr_addr (list_wa),
      .wr_data (reg_wdata),
      .rd_addr ({bank_q, fetch_addr_q[12:2]}),
      .rd_data (cmd)
   );

   // fetch state sequencing
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         dlr_pkg::ST_IDLE:  if (line_go && (ok_q || take_swap)) st_d = dlr_pkg::ST_FETCH;
         dlr_pkg::ST_FETCH: begin
            if (line_go) st_d = dlr_pkg::ST_FETCH;
            else if (dl_stop || fetch_full) st_d = dlr_pkg::ST_DONE;
         end
         dlr_pkg::ST_DONE:  if (line_go) st_d = dlr_pkg::ST_FETCH;
         default:           st_d = dlr_pkg::ST_IDLE;
      endcase
      if (!run) st_d = dlr_pkg::ST_IDLE;
   end

   // control registers; orientation applies at once, nothing else touched
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         orient_q <= dlr_pkg::ROT_RST;
         pclk_q   <= dlr_pkg::PCLK_RST;
         hcyc_q   <= dlr_pkg::HCYC_RST;
         rdata_q  <= 32'h0000_0000;
      end else begin
         if (wr_rot)  orient_q <= reg_wdata[2:0];
         if (wr_pclk) pclk_q   <= reg_wdata[7:0];
         if (wr_hcyc) hcyc_q   <= reg_wdata[11:0];
         rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // swap, bank and overrun flags; a new request beats the clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bank_q <= 1'b0;
         pend_q <= 1'b0;
         ok_q   <= 1'b0;
         ovr_q  <= 1'b0;
      end else begin
         if (take_swap) bank_q <= ~bank_q;
         pend_q <= swap_req | (pend_q & ~take_swap);
         ok_q   <= ok_q | take_swap;
         ovr_q  <= (st_q == dlr_pkg::ST_FETCH && (line_go || fetch_full)) |
                   (ovr_q & ~ovr_clr);
      end
   end

   // scan-out counters and fetch address
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         line_cnt_q   <= 20'h00000;
         row_q        <= 12'h000;
         fetch_addr_q <= 14'h0000;
         rd_vld_q     <= 1'b0;
         st_q         <= dlr_pkg::ST_IDLE;
      end else begin
         st_q       <= st_d;
         line_cnt_q <= line_go ? 20'h00000 : line_cnt_q + 20'h1;
         if (line_go) row_q <= frame_go ? 12'h000 : row_q + 12'h001;
         if (line_go) fetch_addr_q <= 14'h0000;
         else if (fetch_adv) fetch_addr_q <= fetch_addr_q + dlr_pkg::CMD_BYTES;
         rd_vld_q <= fetch_adv;
      end
   end

   // graphics state, restored to defaults at the start of every line
   always_ff @(posedge clk) begin
      if (sys_rst || line_go) begin
         kind_q  <= dlr_pkg::PK_NONE;
         have_q  <= 1'b0;
         px_q    <= 12'h000;
         py_q    <= 12'h000;
         rgb_q   <= dlr_pkg::RGB_WHITE;
         alpha_q <= dlr_pkg::ALPHA_MAX;
         lw_q    <= dlr_pkg::LW_RST;
         vfmt_q  <= dlr_pkg::VFMT_RST;
         filt_q  <= 1'b0;
         fmtc_q  <= 1'b0;
         for (int i = 0; i < 6; i++) begin
            coef_q[i] <= (i == 0 || i == 4) ? dlr_pkg::COEF_ONE : dlr_pkg::COEF_ZERO;
         end
      end else if (cmd_vld) begin
         have_q <= have_d;
         if (vtx_cmd) begin
            px_q <= rx;
            py_q <= ry;
         end
         if (is_op && op == dlr_pkg::OP_BEGIN)  kind_q <= cmd[3:0];
         if (is_op && op == dlr_pkg::OP_BEGIN)  have_q <= 1'b0;
         if (is_op && op == dlr_pkg::OP_END)    kind_q <= dlr_pkg::PK_NONE;
         if (is_op && op == dlr_pkg::OP_RGB)    rgb_q <= cmd[23:0];
         if (is_op && op == dlr_pkg::OP_ALPHA)  alpha_q <= cmd[7:0];
         if (is_op && op == dlr_pkg::OP_LWIDTH) lw_q <= cmd[11:0];
         if (is_op && op == dlr_pkg::OP_VFMT)   vfmt_q <= cmd[2:0];
         if (is_op && op == dlr_pkg::OP_BMODE)  filt_q <= cmd[0];
         if (is_op && op == dlr_pkg::OP_BMODE)  fmtc_q <= cmd[1];
         if (op_xf) coef_q[op[2:0]] <= cmd[15:0];
      end
   end

   // primitive output stage and timing pulses
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pv_q   <= 1'b0;
         pk_q   <= dlr_pkg::PK_NONE;
         px0_q  <= 12'h000;
         py0_q  <= 12'h000;
         px1_q  <= 12'h000;
         py1_q  <= 12'h000;
         prad_q <= 8'h00;
         prgb_q <= dlr_pkg::RGB_WHITE;
         palpha_q <= dlr_pkg::ALPHA_MAX;
         pu_q   <= 16'h0000;
         pv16_q <= 16'h0000;
         prate_q <= dlr_pkg::RATE_NEAR;
         fpul_q <= 1'b0;
         lpul_q <= 1'b0;
      end else begin
         pv_q   <= emit;
         fpul_q <= frame_go;
         lpul_q <= line_go;
         if (emit) begin
            pk_q     <= kind_q;
            px0_q    <= e_x0;
            py0_q    <= e_y0;
            px1_q    <= e_x1;
            py1_q    <= e_y1;
            prad_q   <= e_rad;
            prgb_q   <= rgb_q;
            palpha_q <= alpha_q;
            pu_q     <= u_sum[23:8];
            pv16_q   <= v_sum[23:8];
            prate_q  <= rate;
         end
      end
   end

   // outputs straight from registers
   assign reg_rdata   = rdata_q;
   assign frame_pulse = fpul_q;
   assign line_pulse  = lpul_q;
   assign orientation = orient_q;
   assign overrun     = ovr_q;
   assign prim_valid  = pv_q;
   assign prim_kind   = pk_q;
   assign prim_x0     = px0_q;
   assign prim_y0     = py0_q;
   assign prim_x1     = px1_q;
   assign prim_y1     = py1_q;
   assign prim_radius = prad_q;
   assign prim_rgb    = prgb_q;
   assign prim_alpha  = palpha_q;
   assign prim_u      = pu_q;
   assign prim_v      = pv16_q;
   assign prim_rate   = prate_q;

   // checks on the block's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_SWAP_PEND: assert property (swap_req |=> pend_q)
      else $error("swap request not held pending");
   AST_SWAP_FRAME: assert property (take_swap |=> bank_q != $past(bank_q) && pend_q == $past(swap_req))
      else $error("bank did not change at frame refresh");
   AST_FETCH_BASE: assert property (line_go && run && st_d == dlr_pkg::ST_FETCH |=> fetch_addr_q == 14'h0 ##1 rd_vld_q)
      else $error("fetch did not start at list base");
   AST_FETCH_STEP: assert property (fetch_adv |=> fetch_addr_q == $past(fetch_addr_q) + 14'h4)
      else $error("fetch address did not step by four");
   AST_DISPLAY_STOP: assert property (dl_stop && !line_go |=> st_q == dlr_pkg::ST_DONE ##1 !cmd_vld)
      else $error("fetch went on after display command");
   AST_ROT_NOW: assert property (wr_rot |=> orientation == $past(reg_wdata[2:0]))
      else $error("orientation write not applied at once");
   AST_LINE_MIN: assert property (line_go |-> line_cnt_q >= dlr_pkg::MIN_LINE_CYC - 20'h1 ##1 line_pulse)
      else $error("line shorter than the minimum");
   AST_WHITE_DEFAULT: assert property (line_go |=> rgb_q == dlr_pkg::RGB_WHITE && alpha_q == dlr_pkg::ALPHA_MAX)
      else $error("colour defaults not restored");
   AST_RECT_GROW: assert property (emit && is_rect |=>
      prim_x1 == 12'($past(rx) + $past(w)) && prim_radius == $past(lw_q[11:4]))
      else $error("rectangle not grown by width");

   COV_SWAP: cover property (take_swap);
   COV_RECT: cover property (emit && is_rect);
   COV_OVERRUN: cover property ($rose(ovr_q));
endmodule

// *** tb/dlr_host_model.sv ***
// host model: drives the register port and loads display lists
`timescale 1ns/1ps
module dlr_host_model (
   // clock
   input  wire logic        clk,
   // register port
   output logic      [13:0] reg_addr,
   output logic      [31:0] reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [31:0] reg_rdata
);
   // idle bus from time zero
   initial begin
      reg_addr = 14'h0000;
      reg_wdata = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one-cycle write strobe beside address and data
   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // one-cycle read strobe; data stands only in the next cycle
   task automatic rd(input logic [13:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // list word into the window; lists stay far below 2048 words
   task automatic put(input logic [10:0] i, input logic [31:0] d);
      wr({1'b1, i, 2'b00}, d);
   endtask
   // request activation at the next frame
   task automatic swap();
      wr(dlr_pkg::OFS_SWAP, {24'h000000, dlr_pkg::SWAP_FRAME});
   endtask
   // clear word opening every list; the renderer treats it as a no-op
   localparam logic [31:0] CLEAR_WORD = 32'h26000000;
   task automatic clr(input logic [10:0] i);
      put(i, CLEAR_WORD);
   endtask
endmodule

// *** tb/dlr_top_tb.sv ***
// self-checking bench of the display list renderer
`timescale 1ns/1ps
module dlr_top_tb;
   localparam int W = 480;
   localparam int H = 272;
   logic clk, sys_rst, reg_wr, reg_rd, frame_pulse, line_pulse, overrun, prim_valid;
   logic [13:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [2:0] orientation;
   logic [3:0] prim_kind;
   logic [11:0] prim_x0, prim_y0, prim_x1, prim_y1;
   logic [7:0] prim_radius, prim_alpha;
   logic [23:0] prim_rgb;
   logic [15:0] prim_u, prim_v;
   logic [4:0] prim_rate;
   int num_errors = 0;
   int num_checks = 0;
   dlr_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   dlr_top #(.SCR_W(W), .SCR_H(H), .FRAME_LINES(2)) dut (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .frame_pulse(frame_pulse), .line_pulse(line_pulse),
      .orientation(orientation), .overrun(overrun), .prim_valid(prim_valid),
      .prim_kind(prim_kind), .prim_x0(prim_x0), .prim_y0(prim_y0), .prim_x1(prim_x1),
      .prim_y1(prim_y1), .prim_radius(prim_radius), .prim_rgb(prim_rgb),
      .prim_alpha(prim_alpha), .prim_u(prim_u), .prim_v(prim_v), .prim_rate(prim_rate));
   // free-running 100 MHz clock
   always #5 clk = ~clk;
   // compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // verdict and end of run
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // bounded wait for the next emitted primitive
   task automatic wait_prim(input logic [3:0] k, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (!(prim_valid === 1'b1 && prim_kind === k) && n < lim);
      chk("prim_valid", {31'h0, prim_valid === 1'b1 && prim_kind === k}, 32'h1);
      if (prim_valid !== 1'b1 || prim_kind !== k) begin
         complete_run();
      end
   endtask
   // defaults after reset
   task automatic t_reset();
      #1;
      chk("rgb", prim_rgb, 32'hffffff);
      chk("alpha", prim_alpha, 32'hff);
      chk("rate", prim_rate, 32'h10);
      chk("orient", orientation, 32'h0);
      $display("test reset done");
   endtask
   // every orientation code takes effect at once
   task automatic t_orient();
      for (int i = 7; i >= 0; i--) begin
         host.wr(dlr_pkg::OFS_ROTATE, 32'(i));
         #1;
         chk("orient", orientation, 32'(i));
      end
      $display("test orientation done");
   endtask
   // list of bitmap, alpha, bilinear text mode, one vertex, display
   task automatic t_list();
      host.wr(dlr_pkg::OFS_PCLK, 32'h1);
      host.wr(dlr_pkg::OFS_HCYCLE, 32'h1);
      host.clr(11'h000);
      host.put(11'h001, 32'h01000002);
      host.put(11'h002, 32'h04000080);
      host.put(11'h003, 32'h07000003);
      host.put(11'h004, 32'h80005014);
      host.put(11'h005, 32'h00000000);
      host.swap();
      host.rd(dlr_pkg::OFS_SWAP, rv);
      chk("swap pending", rv, 32'h2);
      wait_prim(4'h2, 12000);
      chk("kind", prim_kind, 32'h2);
      chk("x0", prim_x0, 32'd10);
      chk("y0", prim_y0, 32'd20);
      chk("u", prim_u, 32'd10);
      chk("v", prim_v, 32'd20);
      chk("alpha", prim_alpha, 32'h80);
      chk("rgb", prim_rgb, 32'hffffff);
      chk("rate", prim_rate, 32'h2);
      chk("radius", prim_radius, 32'h0);
      host.rd(dlr_pkg::OFS_STATUS, rv);
      chk("active", rv[dlr_pkg::ST_OK_BIT], 32'h1);
      chk("pending", rv[dlr_pkg::ST_PEND_BIT], 32'h0);
      host.rd(14'h0020, rv);
      chk("unmapped", rv, 32'h0);
      $display("test list done");
   endtask
   // inverted landscape maps the same vertex to the far corner
   task automatic t_rotate();
      host.wr(dlr_pkg::OFS_ROTATE, 32'h1);
      wait_prim(4'h2, 3000);
      chk("rot x0", prim_x0, 32'(W - 1 - 10));
      chk("rot y0", prim_y0, 32'(H - 1 - 20));
      $display("test rotation done");
   endtask
   // bounded wait for a line pulse, counting cycles and frame pulses
   task automatic wait_line(output int n, inout int f);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
         if (frame_pulse === 1'b1) begin
            f++;
         end
      end while (line_pulse !== 1'b1 && n < 5000);
      if (line_pulse !== 1'b1) begin
         chk("line_pulse", 32'h0, 32'h1);
         complete_run();
      end
   endtask
   // minimum line length, one frame pulse per two lines, no overrun
   task automatic t_timing();
      int n;
      int f;
      f = 0;
      wait_line(n, f);
      f = 0;
      wait_line(n, f);
      chk("line cycles", 32'(n), 32'd2048);
      wait_line(n, f);
      chk("line cycles", 32'(n), 32'd2048);
      chk("frame pulses", 32'(f), 32'd1);
      chk("overrun", {31'h0, overrun}, 32'h0);
      $display("test timing done");
   endtask
   // rectangle grows by the width both ways, width is the corner radius
   task automatic t_rect();
      host.wr(dlr_pkg::OFS_ROTATE, 32'h0);
      host.clr(11'h000);
      host.put(11'h001, 32'h01000005);
      host.put(11'h002, 32'h05000020);
      host.put(11'h003, 32'h80005014);
      host.put(11'h004, 32'h8000f028);
      host.put(11'h005, 32'h00000000);
      host.swap();
      wait_prim(4'h5, 12000);
      chk("kind", prim_kind, 32'h5);
      chk("rect x0", prim_x0, 32'd8);
      chk("rect y0", prim_y0, 32'd18);
      chk("rect x1", prim_x1, 32'd32);
      chk("rect y1", prim_y1, 32'd42);
      chk("rect radius", prim_radius, 32'd2);
      host.rd(dlr_pkg::OFS_STATUS, rv);
      chk("bank", rv[dlr_pkg::ST_BANK_BIT], 32'h0);
      $display("test rectangle done");
   endtask
   // reset then scenarios
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_orient();
      t_list();
      t_rotate();
      t_timing();
      t_rect();
      complete_run();
   end
endmodule
